// ==== accum_alu_pkg.sv ====
// constants, opcode patterns and flag layout for the accumulator datapath
// ==========================================
// Overview of operation
// - absolute value replaces the chosen accumulator with its own magnitude.
// - add-with-carry adds source, carry and destination; 48-bit sources into 56 bits.
// - add-with-carry one-bit source field picks long pair X or Y.
// - add-with-carry carry is exact only when extension equals sign of bit 47.
// - plain add takes word, long, accumulator, short or long immediate sources.
// - short immediate is unsigned, right aligned, zero filled to 24 bits.
// - register add uses three-bit field: other acc, X, Y, X0, Y0, X1, Y1.
// - long-immediate add takes its 24-bit operand from the extension word.
// - one destination bit selects accumulator A or B for the result.
// - accumulator source carry is exact; narrower sources need sign-extended part.
// - shift-left-add doubles destination, zero into lsb, adds source, stores.
// - shift-left-add sets overflow on sum overflow or msb change by shift.
// - shift-left-add carry is valid only when the pre-shift does not overflow.
// - both shift-add forms use the other accumulator as the source.
// - shift-right-add halves destination keeping msb, adds source, stores.
// - shift-right-add carry exact; overflow only from the addition step.
// - overflow set when result is unrepresentable, 40 bits in sixteen-bit mode.
// - carry is taken out of bit 55 of the sum; absolute value leaves it unchanged.
// - a parallel move sees the accumulator value from before the operation.
package accum_alu_pkg;

  // widths
  localparam int ACC_W = 56;
  localparam int WORD_W = 24;
  localparam int LONG_W = 48;
  localparam int SHORT_W = 6;
  localparam int EXT_W = 8;
  localparam int SIXTEEN_W = 40;

  // condition flag bit positions
  localparam int FLG_S = 7;
  localparam int FLG_L = 6;
  localparam int FLG_E = 5;
  localparam int FLG_U = 4;
  localparam int FLG_N = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_V = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // instruction field positions
  localparam int DEST_BIT = 3;
  localparam int ADC_SRC_BIT = 4;
  localparam int ADD_SRC_LSB = 4;
  localparam int SHORT_LSB = 8;

  // low-byte opcode patterns (mask, value)
  localparam logic [7:0] ABS_MASK = 8'hf7;
  localparam logic [7:0] ABS_VAL = 8'h26;
  localparam logic [7:0] ADC_MASK = 8'he7;
  localparam logic [7:0] ADC_VAL = 8'h21;
  localparam logic [7:0] ADDR_MASK = 8'h87;
  localparam logic [7:0] ADDR_VAL = 8'h00;
  localparam logic [7:0] SHL_MASK = 8'hf7;
  localparam logic [7:0] SHL_VAL = 8'h12;
  localparam logic [7:0] SHR_MASK = 8'hf7;
  localparam logic [7:0] SHR_VAL = 8'h02;
  // full-word patterns for immediate forms
  localparam logic [23:0] SIMM_MASK = 24'hffc0f7;
  localparam logic [23:0] SIMM_VAL = 24'h014080;
  localparam logic [23:0] LIMM_MASK = 24'hfffff7;
  localparam logic [23:0] LIMM_VAL = 24'h0140c0;

  // register-add source field codes
  localparam logic [2:0] ADD_SRC_NONE = 3'h0;
  localparam logic [2:0] ADD_SRC_ACC = 3'h1;
  localparam logic [2:0] ADD_SRC_X = 3'h2;
  localparam logic [2:0] ADD_SRC_Y = 3'h3;
  localparam logic [2:0] ADD_SRC_X0 = 3'h4;
  localparam logic [2:0] ADD_SRC_Y0 = 3'h5;
  localparam logic [2:0] ADD_SRC_X1 = 3'h6;
  localparam logic [2:0] ADD_SRC_Y1 = 3'h7;

  // scaling modes {s1,s0}
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_DOWN = 2'h1;
  localparam logic [1:0] SCALE_UP = 2'h2;

  // lsb of the signed integer part per scaling mode
  localparam logic [5:0] INT_LSB_NONE = 6'h2f;
  localparam logic [5:0] INT_LSB_DOWN = 6'h30;
  localparam logic [5:0] INT_LSB_UP = 6'h2e;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ABS,
    OP_ADC,
    OP_ADD,
    OP_SHL_ADD,
    OP_SHR_ADD
  } alu_op_t;

endpackage : accum_alu_pkg

// ==== accumulator_add_abs_datapath.sv ====
// accumulator datapath for absolute value, add with carry, add and shift-add
`timescale 1ns/1ps
module accumulator_add_abs_datapath (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // instruction from decode
  input wire logic instr_valid_i,
  input wire logic [accum_alu_pkg::WORD_W-1:0] instr_word_i,
  input wire logic [accum_alu_pkg::WORD_W-1:0] ext_word_i,
  // register file operands
  input wire logic [accum_alu_pkg::WORD_W-1:0] x0_i,
  input wire logic [accum_alu_pkg::WORD_W-1:0] x1_i,
  input wire logic [accum_alu_pkg::WORD_W-1:0] y0_i,
  input wire logic [accum_alu_pkg::WORD_W-1:0] y1_i,
  // mode inputs
  input wire logic [1:0] scale_mode_i,
  input wire logic sixteen_bit_mode_i,
  // accumulator load from parallel move
  input wire logic acc_wr_i,
  input wire logic acc_wr_sel_i,
  input wire logic [accum_alu_pkg::ACC_W-1:0] acc_wr_data_i,
  // condition flag load from other instructions
  input wire logic flag_wr_i,
  input wire logic [7:0] flag_wr_data_i,
  // state out
  output logic [accum_alu_pkg::ACC_W-1:0] accum_a_o,
  output logic [accum_alu_pkg::ACC_W-1:0] accum_b_o,
  output logic [7:0] condition_flag_register_o,
  output logic op_done_o
);
  import accum_alu_pkg::*;

  // ==========================================
  // helpers
  function automatic logic op_match(input logic [7:0] b, input logic [7:0] m,
                                    input logic [7:0] v);
    op_match = ((b & m) == v);
  endfunction : op_match

  function automatic logic word_match(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] m,
                                      input logic [WORD_W-1:0] v);
    word_match = ((w & m) == v);
  endfunction : word_match

  // high when bits ACC_W-1 down to lsb are not all equal
  function automatic logic mixed_above(input logic [ACC_W-1:0] r, input logic [5:0] lsb);
    logic ones;
    logic zeros;
    ones = 1'b1;
    zeros = 1'b1;
    for (int i = 0; i < ACC_W; i++)
    begin
      if (i >= int'(lsb))
      begin
        ones = ones & r[i];
        zeros = zeros & ~r[i];
      end
    end
    mixed_above = !(ones || zeros);
  endfunction : mixed_above

  // word operand sits in bits 47:24, sign extended, low part zero
  function automatic logic [ACC_W-1:0] word_to_acc(input logic [WORD_W-1:0] w);
    word_to_acc = {{EXT_W{w[WORD_W-1]}}, w, {WORD_W{1'b0}}};
  endfunction : word_to_acc

  function automatic logic [ACC_W-1:0] long_to_acc(input logic [WORD_W-1:0] hi,
                                                   input logic [WORD_W-1:0] lo);
    long_to_acc = {{EXT_W{hi[WORD_W-1]}}, hi, lo};
  endfunction : long_to_acc

  // ==========================================
  // state
  logic [ACC_W-1:0] accum_a_reg;
  logic [ACC_W-1:0] accum_a_next;
  logic [ACC_W-1:0] accum_b_reg;
  logic [ACC_W-1:0] accum_b_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic op_done_reg;

  // ==========================================
  // decode
  wire logic [7:0] low_byte = instr_word_i[7:0];
  wire logic dest_b = instr_word_i[DEST_BIT];
  wire logic [2:0] add_source_select_field = instr_word_i[ADD_SRC_LSB+2:ADD_SRC_LSB];
  wire logic is_abs = op_match(low_byte, ABS_MASK, ABS_VAL);
  wire logic is_adc = op_match(low_byte, ADC_MASK, ADC_VAL);
  wire logic is_shl_add = op_match(low_byte, SHL_MASK, SHL_VAL);
  wire logic is_shr_add = op_match(low_byte, SHR_MASK, SHR_VAL);
  wire logic is_add_reg = op_match(low_byte, ADDR_MASK, ADDR_VAL) &&
                          (add_source_select_field != ADD_SRC_NONE);
  wire logic is_add_simm = word_match(instr_word_i, SIMM_MASK, SIMM_VAL);
  wire logic is_add_limm = word_match(instr_word_i, LIMM_MASK, LIMM_VAL);

  alu_op_t op;
  always_comb
  begin
    op = OP_NONE;
    if (instr_valid_i)
    begin
      if (is_abs)
        op = OP_ABS;
      else if (is_adc)
        op = OP_ADC;
      else if (is_shl_add)
        op = OP_SHL_ADD;
      else if (is_shr_add)
        op = OP_SHR_ADD;
      else if (is_add_reg || is_add_simm || is_add_limm)
        op = OP_ADD;
    end
  end

  // ==========================================
  // operand selection
  wire logic [ACC_W-1:0] dest_val = dest_b ? accum_b_reg : accum_a_reg;
  wire logic [ACC_W-1:0] other_acc = dest_b ? accum_a_reg : accum_b_reg;
  wire logic [ACC_W-1:0] long_x = long_to_acc(x1_i, x0_i);
  wire logic [ACC_W-1:0] long_y = long_to_acc(y1_i, y0_i);
  wire logic [ACC_W-1:0] adc_src = instr_word_i[ADC_SRC_BIT] ? long_y : long_x;
  // short immediate: unsigned, right aligned in a 24-bit word
  wire logic [WORD_W-1:0] short_word =
    {{(WORD_W-SHORT_W){1'b0}}, instr_word_i[SHORT_LSB+SHORT_W-1:SHORT_LSB]};
  wire logic [ACC_W-1:0] simm_src = word_to_acc(short_word);
  wire logic [ACC_W-1:0] limm_src = word_to_acc(ext_word_i);

  logic [ACC_W-1:0] reg_src;
  always_comb
  begin
    unique case (add_source_select_field)
      ADD_SRC_ACC: reg_src = other_acc;
      ADD_SRC_X: reg_src = long_x;
      ADD_SRC_Y: reg_src = long_y;
      ADD_SRC_X0: reg_src = word_to_acc(x0_i);
      ADD_SRC_Y0: reg_src = word_to_acc(y0_i);
      ADD_SRC_X1: reg_src = word_to_acc(x1_i);
      ADD_SRC_Y1: reg_src = word_to_acc(y1_i);
      default: reg_src = '0;
    endcase
  end

  wire logic [ACC_W-1:0] add_src = is_add_simm ? simm_src :
                                   is_add_limm ? limm_src : reg_src;

  // ==========================================
  // pre-shift of the destination and source per operation
  logic [ACC_W-1:0] pre_d;
  logic [ACC_W-1:0] src;
  logic cin;
  logic shift_ovf;
  always_comb
  begin
    pre_d = dest_val;
    src = '0;
    cin = 1'b0;
    shift_ovf = 1'b0;
    unique case (op)
      OP_ADC:
      begin
        src = adc_src;
        cin = flags_reg[FLG_C];
      end
      OP_ADD:
        src = add_src;
      OP_SHL_ADD:
      begin
        pre_d = {dest_val[ACC_W-2:0], 1'b0};
        src = other_acc;
        shift_ovf = dest_val[ACC_W-1] ^ dest_val[ACC_W-2];
      end
      OP_SHR_ADD:
      begin
        pre_d = {dest_val[ACC_W-1], dest_val[ACC_W-1:1]};
        src = other_acc;
      end
      default:
      begin
        pre_d = dest_val;
        src = '0;
      end
    endcase
  end

  // ==========================================
  // adder and magnitude
  // carry out of bit 55; with ADC it follows from the sum, so the extension
  // part must track bit 47 for multiprecision chains
  wire logic [ACC_W:0] sum_wide = {1'b0, pre_d} + {1'b0, src} + {{ACC_W{1'b0}}, cin};
  wire logic [ACC_W-1:0] sum = sum_wide[ACC_W-1:0];
  wire logic sum_carry = sum_wide[ACC_W];
  wire logic sum_ovf = (pre_d[ACC_W-1] == src[ACC_W-1]) &&
                       (sum[ACC_W-1] != pre_d[ACC_W-1]);
  wire logic [ACC_W-1:0] neg_d = ACC_W'(~dest_val + 1'b1);
  wire logic [ACC_W-1:0] abs_res = dest_val[ACC_W-1] ? neg_d : dest_val;
  // only the most negative value cannot be negated
  wire logic abs_ovf = dest_val[ACC_W-1] && neg_d[ACC_W-1];

  wire logic is_abs_op = (op == OP_ABS);
  wire logic [ACC_W-1:0] result = is_abs_op ? abs_res : sum;
  wire logic ovf56 = is_abs_op ? abs_ovf : (sum_ovf | shift_ovf);
  // sixteen-bit mode: result must fit in 40 bits
  wire logic fit40 = !mixed_above(result, 6'(SIXTEEN_W - 1));
  wire logic res_ovf = ovf56 || (sixteen_bit_mode_i && !fit40);

  // ==========================================
  // standard flag definitions
  // scaling mode picks the lsb of the signed integer part; u compares it with the bit below
  wire logic [5:0] int_lsb = (scale_mode_i == SCALE_DOWN) ? INT_LSB_DOWN :
                             (scale_mode_i == SCALE_UP) ? INT_LSB_UP : INT_LSB_NONE;
  wire logic ext_flag = mixed_above(result, int_lsb);
  wire logic unorm_flag = !(result[int_lsb] ^ result[int_lsb - 6'h1]);

  wire logic alu_active = (op != OP_NONE);
  wire logic carry_new = is_abs_op ? flags_reg[FLG_C] : sum_carry;

  always_comb
  begin
    flags_next = flags_reg;
    if (alu_active)
    begin
      flags_next[FLG_L] = flags_reg[FLG_L] | res_ovf;
      flags_next[FLG_E] = ext_flag;
      flags_next[FLG_U] = unorm_flag;
      flags_next[FLG_N] = result[ACC_W-1];
      flags_next[FLG_Z] = (result == '0);
      flags_next[FLG_V] = res_ovf;
      flags_next[FLG_C] = carry_new;
    end
    else if (flag_wr_i)
      flags_next = flag_wr_data_i;
  end

  // ==========================================
  // accumulator write-back; alu result wins over a move to the same one
  always_comb
  begin
    accum_a_next = accum_a_reg;
    accum_b_next = accum_b_reg;
    if (acc_wr_i && !acc_wr_sel_i)
      accum_a_next = acc_wr_data_i;
    if (acc_wr_i && acc_wr_sel_i)
      accum_b_next = acc_wr_data_i;
    if (alu_active && !dest_b)
      accum_a_next = result;
    if (alu_active && dest_b)
      accum_b_next = result;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      accum_a_reg <= '0;
      accum_b_reg <= '0;
      flags_reg <= FLAGS_RESET;
      op_done_reg <= 1'b0;
    end
    else
    begin
      accum_a_reg <= accum_a_next;
      accum_b_reg <= accum_b_next;
      flags_reg <= flags_next;
      op_done_reg <= alu_active;
    end
  end

  // ==========================================
  // outputs hold the pre-operation value through the executing cycle
  assign accum_a_o = accum_a_reg;
  assign accum_b_o = accum_b_reg;
  assign condition_flag_register_o = flags_reg;
  assign op_done_o = op_done_reg;

endmodule : accumulator_add_abs_datapath

// ==== accum_alu_chk.sv ====
// assertion checker for the accumulator datapath
`timescale 1ns/1ps
module accum_alu_chk
  import accum_alu_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // watched ports
  input wire logic instr_valid_i,
  input wire logic [accum_alu_pkg::WORD_W-1:0] instr_word_i,
  input wire logic [accum_alu_pkg::WORD_W-1:0] x0_i,
  input wire logic [accum_alu_pkg::WORD_W-1:0] x1_i,
  input wire logic [accum_alu_pkg::ACC_W-1:0] accum_a_o,
  input wire logic [accum_alu_pkg::ACC_W-1:0] accum_b_o,
  input wire logic [7:0] condition_flag_register_o,
  input wire logic op_done_o
);
  // ==========================================
  // decode of the watched forms, all with destination A
  wire [7:0] lo = instr_word_i[7:0];
  wire v = instr_valid_i;
  wire abs_a = v && lo == 8'h26;
  wire adc_a = v && lo == 8'h21;
  wire shl_a = v && lo == 8'h12;
  wire shr_a = v && lo == 8'h02;
  wire add_ba = v && lo == 8'h10;
  wire simm_a = v && (instr_word_i & SIMM_MASK) == SIMM_VAL && !instr_word_i[DEST_BIT];
  wire bad = v && instr_word_i == 24'h000000;
  wire [56:0] sum_ab = {1'b0, accum_a_o} + {1'b0, accum_b_o};
  wire [55:0] xl = {{8{x1_i[23]}}, x1_i, x0_i};
  wire [7:0] f = condition_flag_register_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ==========================================
  // assertions
  chk_abs_magnitude: assert property (abs_a |=> op_done_o && accum_a_o ==
    ($past(accum_a_o[55]) ? -$past(accum_a_o) : $past(accum_a_o))) else $error("abs result");
  chk_abs_carry: assert property (abs_a |=> $stable(f[FLG_C])) else $error("abs carry");
  chk_adc_sum: assert property (adc_a |=> accum_a_o == $past(accum_a_o + xl + f[FLG_C]))
    else $error("adc sum");
  chk_shl_sum: assert property (shl_a |=>
    accum_a_o == $past({accum_a_o[54:0], 1'b0} + accum_b_o)) else $error("shl sum");
  chk_shl_ovf: assert property (shl_a && (accum_a_o[55] ^ accum_a_o[54]) |=> f[FLG_V])
    else $error("shl overflow");
  chk_shr_sum: assert property (shr_a |=>
    accum_a_o == $past({accum_a_o[55], accum_a_o[55:1]} + accum_b_o)) else $error("shr sum");
  chk_add_carry: assert property (add_ba |=> f[FLG_C] == $past(sum_ab[56]))
    else $error("add carry");
  chk_short_imm: assert property (simm_a |=>
    accum_a_o == $past(accum_a_o + {26'h0, instr_word_i[13:8], 24'h0})) else $error("short imm");
  chk_undecoded_word: assert property (bad |=> !op_done_o) else $error("refused word");
  cover property (abs_a);
  cover property (shl_a);
  cover property (adc_a);
endmodule : accum_alu_chk

bind accumulator_add_abs_datapath accum_alu_chk i_accum_alu_chk (.clk_i, .srst_i,
  .instr_valid_i, .instr_word_i, .x0_i, .x1_i, .accum_a_o, .accum_b_o,
  .condition_flag_register_o, .op_done_o);

// ==== core_feed_model.sv ====
// decoder and register file model feeding the datapath
`timescale 1ns/1ps
module core_feed_model (
  // clock
  input wire logic clk_i,
  // instruction and operands
  output logic instr_valid_o,
  output logic [23:0] instr_word_o,
  output logic [23:0] ext_word_o,
  output logic [23:0] x0_o,
  output logic [23:0] x1_o,
  output logic [23:0] y0_o,
  output logic [23:0] y1_o
);
  initial
  begin
    instr_valid_o = 1'b0;
    instr_word_o = 24'h000000;
    ext_word_o = 24'h000000;
    {x0_o, x1_o, y0_o, y1_o} = 96'h0;
  end
  task regs(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c,
    input logic [23:0] d);
    {x0_o, x1_o, y0_o, y1_o} = {a, b, c, d};
  endtask : regs
  // one instruction for one cycle, extension word beside it
  task issue(input logic [23:0] w, input logic [23:0] e);
    @(negedge clk_i);
    instr_valid_o = 1'b1;
    instr_word_o = w;
    ext_word_o = e;
    @(negedge clk_i);
    instr_valid_o = 1'b0;
    instr_word_o = ~w;
    ext_word_o = ~e;
  endtask : issue
endmodule : core_feed_model

// ==== tb.sv ====
// self-checking bench for the accumulator datapath
`timescale 1ns/1ps
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
  import accum_alu_pkg::*;
  logic clk_i, srst_i, instr_valid_i, acc_wr_i, acc_wr_sel_i, flag_wr_i, op_done_o;
  logic [23:0] instr_word_i, ext_word_i, x0_i, x1_i, y0_i, y1_i;
  logic [1:0] scale_mode_i = 2'h0;
  logic sixteen_bit_mode_i = 1'b0;
  logic [55:0] acc_wr_data_i, accum_a_o, accum_b_o, e;
  logic [7:0] flag_wr_data_i, f;
  int err_count = 0;
  int compares = 0;
  core_feed_model i_core_feed_model (.clk_i, .instr_valid_o(instr_valid_i),
    .instr_word_o(instr_word_i), .ext_word_o(ext_word_i), .x0_o(x0_i), .x1_o(x1_i),
    .y0_o(y0_i), .y1_o(y1_i));
  accumulator_add_abs_datapath i_accumulator_add_abs_datapath (.clk_i, .srst_i,
    .instr_valid_i, .instr_word_i, .ext_word_i, .x0_i, .x1_i, .y0_i, .y1_i, .scale_mode_i,
    .sixteen_bit_mode_i, .acc_wr_i, .acc_wr_sel_i, .acc_wr_data_i, .flag_wr_i,
    .flag_wr_data_i, .accum_a_o, .accum_b_o, .condition_flag_register_o(f), .op_done_o);
  // ==========================================
  // helpers
  task stop_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task ld(input logic s, input logic [55:0] v);
    @(negedge clk_i);
    {acc_wr_i, acc_wr_sel_i, acc_wr_data_i} = {1'b1, s, v};
    @(negedge clk_i);
    {acc_wr_i, acc_wr_data_i} = {1'b0, ~v};
  endtask : ld
  task fl(input logic [7:0] v);
    @(negedge clk_i);
    {flag_wr_i, flag_wr_data_i} = {1'b1, v};
    @(negedge clk_i);
    flag_wr_i = 1'b0;
  endtask : fl
  task run(input logic [23:0] w, input logic [23:0] x);
    int n;
    i_core_feed_model.issue(w, x);
    n = 0;
    while (op_done_o !== 1'b1 && n < 4)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n == 4)
    begin
      err_count++;
      stop_test;
    end
  endtask : run
  // ==========================================
  // scenarios
  task t_abs_adc;
    ld(0, 56'hff_fffffb_000000);
    fl(8'h01);
    run(24'h000026, 0);
    `CK("abs", 56'h00_000005_000000, accum_a_o)
    `CK("abs_c", 2'b10, {f[FLG_C], f[FLG_N]})
    ld(0, 56'h0);
    fl(8'h01);
    i_core_feed_model.regs(24'h1, 24'h0, 24'h0, 24'h10);
    run(24'h000021, 0);
    `CK("adc_x", 56'h2, accum_a_o)
    run(24'h000031, 0);
    `CK("adc_y", 56'h00_000010_000002, accum_a_o)
  endtask : t_abs_adc
  task t_add;
    i_core_feed_model.regs(24'h1, 24'h2, 24'h3, 24'h4);
    for (int j = 1; j < 8; j++)
    begin
      ld(1, 56'h0);
      ld(0, 56'h100);
      run({16'h0, 1'b0, 3'(j), 4'h8}, 0);
      case (j)
        1: e = 56'h100;
        2: e = 56'h2_000001;
        3: e = 56'h4_000003;
        4: e = 56'h1_000000;
        5: e = 56'h3_000000;
        6: e = 56'h2_000000;
        default: e = 56'h4_000000;
      endcase
      `CK("add_reg", e, accum_b_o)
      `CK("add_keep", 56'h100, accum_a_o)
    end
    ld(0, 56'h1);
    run(24'h017f80, 0);
    `CK("short_imm", 56'h3f_000001, accum_a_o)
    ld(1, 56'h5);
    run(24'h0140c8, 24'h800000);
    `CK("long_imm", 56'hff_800000_000005, accum_b_o)
  endtask : t_add
  task t_shift;
    ld(0, 56'h40_000000_000000);
    ld(1, 56'h3);
    run(24'h000012, 0);
    `CK("shl", 56'h80_000000_000003, accum_a_o)
    `CK("shl_v", 1'b1, f[FLG_V])
    ld(0, 56'h80_000000_000002);
    ld(1, 56'h1);
    run(24'h000002, 0);
    `CK("shr", 56'hc0_000000_000002, accum_a_o)
    `CK("shr_vc", 2'b00, {f[FLG_V], f[FLG_C]})
    run(24'h00000a, 0);
    `CK("shr_b", 56'hc0_000000_000002, accum_b_o)
  endtask : t_shift
  task t_carry;
    ld(0, 56'h80_000000_000000);
    ld(1, 56'h80_000000_000000);
    run(24'h000010, 0);
    `CK("carry", 3'b111, {f[FLG_Z], f[FLG_V], f[FLG_C]})
    ld(0, 56'h7);
    i_core_feed_model.issue(24'h000000, 0);
    `CK("refused", 57'h0_00000000_000007, {op_done_o, accum_a_o})
  endtask : t_carry
  // result 00:800000:000000 through each scaling mode, then the 40-bit range
  task t_flags;
    logic [4:0] ex;
    i_core_feed_model.regs(24'h1, 24'h2, 24'h3, 24'h4);
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk_i);
      scale_mode_i = (k == 3) ? 2'h0 : 2'(k);
      sixteen_bit_mode_i = (k == 3);
      ld(0, 56'h00_7fffff_000000);
      fl(8'h00);
      run(24'h000040, 0);
      case (k)
        0: ex = 5'b10000;
        1: ex = 5'b00000;
        2: ex = 5'b11000;
        default: ex = 5'b10110;
      endcase
      `CK("flags_euvlc", ex, {f[FLG_E], f[FLG_U], f[FLG_V], f[FLG_L], f[FLG_C]})
    end
    @(negedge clk_i);
    {scale_mode_i, sixteen_bit_mode_i} = 3'h0;
    run(24'h000040, 0);
    `CK("sticky_vl", 2'b01, {f[FLG_V], f[FLG_L]})
  endtask : t_flags
  // move beside an op: the other accumulator takes it, the destination keeps the sum
  task t_move;
    ld(0, 56'h0);
    fork
      i_core_feed_model.issue(24'h000040, 0);
      ld(1, 56'h55);
    join
    `CK("move_other", 56'h55, accum_b_o)
    fork
      i_core_feed_model.issue(24'h000040, 0);
      ld(0, 56'h77);
    join
    `CK("move_lost", 57'h1_00000002_000000, {op_done_o, accum_a_o})
  endtask : t_move
  // ==========================================
  // clock, reset and sequence
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    {srst_i, acc_wr_i, acc_wr_sel_i, flag_wr_i} = 4'h8;
    acc_wr_data_i = 56'h0;
    flag_wr_data_i = 8'h00;
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    t_abs_adc;
    t_add;
    t_shift;
    t_carry;
    t_flags;
    t_move;
    stop_test;
  end
  initial
  begin
    #2000000;
    err_count++;
    stop_test;
  end
endmodule : tb
